// ===== design/ump_fifo.sv
// synchronous fifo with count, flush and overflow refusal
module ump_fifo #(
   parameter int W = 8,
   parameter int D = 16,
   parameter int AW = 4
) (
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   input  wire logic          flush_i,
   input  wire logic          push_i,
   input  wire logic [W-1:0]  din_i,
   input  wire logic          pop_i,
   output logic      [W-1:0]  head_o,
   output logic      [AW:0]   count_o,
   output logic               full_o,
   output logic               empty_o
);
   logic [W-1:0] mem [D];
   logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
   logic [AW:0]   next_count;
   logic          do_push, do_pop;

   assign full_o  = count_o == (AW+1)'(D);
   assign empty_o = count_o == '0;
   assign head_o  = mem[rd_ptr];

   always_comb begin
      do_push     = push_i && !full_o;
      do_pop      = pop_i && !empty_o;
      next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (flush_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count  = '0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ptr  <= '0;
         wr_ptr  <= '0;
         count_o <= '0;
      end else begin
         rd_ptr  <= next_rd_ptr;
         wr_ptr  <= next_wr_ptr;
         count_o <= next_count;
      end
   end

   // memory has no reset, written only on accepted push
   always_ff @(posedge mclk_i) begin
      if (do_push && !flush_i) begin
         mem[wr_ptr] <= din_i;
      end
   end
endmodule : ump_fifo

// ===== design/ump_pkg.sv
// shared constants, types and helpers of the host port block
package ump_pkg;
   // mpu-side register byte offsets
   localparam logic [7:0] ADDR_RX_DATA   = 8'h00;
   localparam logic [7:0] ADDR_SHADOW    = 8'h04;
   localparam logic [7:0] ADDR_TX_DATA   = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
   localparam logic [7:0] ADDR_CTRL      = 8'h14;
   localparam logic [7:0] ADDR_PACE      = 8'h18;
   localparam logic [7:0] ADDR_TOUT      = 8'h1C;
   localparam logic [7:0] ADDR_HOST_CFG  = 8'h20;
   localparam logic [7:0] ADDR_HOST_MISC = 8'h24;
   // host-side register offsets
   localparam logic [2:0] HOFF_DATA = 3'h0;
   localparam logic [2:0] HOFF_IER  = 3'h1;
   localparam logic [2:0] HOFF_IIR  = 3'h2;
   localparam logic [2:0] HOFF_LINE = 3'h3;
   localparam logic [2:0] HOFF_MODM = 3'h4;
   localparam logic [2:0] HOFF_LSTS = 3'h5;
   localparam logic [2:0] HOFF_MSR  = 3'h6;
   localparam logic [2:0] HOFF_SCR  = 3'h7;
   // mpu interrupt sources, index 0 has the highest priority
   localparam int SRC_TXWR = 0;
   localparam int SRC_MDM  = 1;
   localparam int SRC_LINE = 2;
   localparam int SRC_DIV  = 3;
   localparam int SRC_FIFO = 4;
   localparam int SRC_RXRD = 5;
   localparam int SRC_TXTO = 6;
   localparam int NSRC     = 7;
   // control register fields
   localparam int CTRL_GIE   = 0;
   localparam int CTRL_MODE2 = 1;
   localparam int CTRL_WAND  = 2;
   localparam int CTRL_PACE  = 3;
   localparam int CTRL_DMA   = 4;
   localparam int CTRL_VEC   = 8;
   // reset values and fixed codes
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [7:0]  RST_OPCODE = 8'hFF;
   localparam logic [3:0]  IIR_NONE   = 4'h1;
   localparam logic [3:0]  IIR_LS     = 4'h6;
   localparam logic [3:0]  IIR_RDA    = 4'h4;
   localparam logic [3:0]  IIR_TO     = 4'hC;
   localparam logic [3:0]  IIR_THRE   = 4'h2;
   localparam logic [3:0]  IIR_MS     = 4'h0;
   localparam logic [7:0]  HOST_BASE  = 8'hF8;

   typedef struct packed {
      logic [7:0] line_control_reg, modem_control_reg, dll, divisor_latch_high, ier;
      logic [7:0] fifo_control_reg, scr, msr;
   } ump_host_regs_s;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       valid;
   } ump_ahb_req_s;

   // receive trigger level from control bits 7:6
   function automatic logic [4:0] ump_trig(input logic [1:0] sel);
      logic [4:0] t;
      t = 5'h01;
      unique case (sel)
         2'b00: t = 5'h01;
         2'b01: t = 5'h04;
         2'b10: t = 5'h08;
         2'b11: t = 5'h0E;
      endcase
      return t;
   endfunction : ump_trig
endpackage : ump_pkg

// ===== design/ump_port.sv
// host serial-port register image with mpu side on ahb-lite
// Contract
// - host writes of data, modem, line, divisor, fifo control and data reads interrupt mpu
// - each mpu source has a mask bit; one global bit disables all
// - mpu interrupt answer supports fixed mode 0 and vectored mode 2
// - two cascaded 8-bit pacing timers on the channel b clock give a delay of high value times low value
// - two 8-bit timers give receive and transmit fifo timeouts
// - host interrupt pin in standard or shared wired-and mode
// - two dma handshake lines pace data register transfers
// - host decode uses only the low eight address lines
// - receive fifo is 16 entries of eight data and three error bits
// - error bits copy from write-only shadow bits, which then self-clear
// - error bits show to host only at fifo head
// - host error flags set from head, cleared only by line status read
// - error flags accumulate across consecutive data reads
// - full host register set, parallel data, no shift register
// - fifo control bits 7:6 pick a 1, 4, 8 or 14 byte trigger
// - transmit fifo holds 16 bytes, host writes, mpu reads
// - host strobes pass two flip-flops; transfers timed by mpu clock
//
// Implementation choices: register access over AHB-Lite and the register addresses.
module ump_port #(
   parameter logic [7:0] BASE = ump_pkg::HOST_BASE
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire logic         hsel_i,
   input  wire logic [31:0]  haddr_i,
   input  wire logic [1:0]   htrans_i,
   input  wire logic         hwrite_i,
   input  wire logic [2:0]   hsize_i,
   input  wire logic [31:0]  hwdata_i,
   input  wire logic         hready_i,
   output logic      [31:0]  hrdata_o,
   output logic              hreadyout_o,
   output logic              hresp_o,
   input  wire logic [7:0]   host_addr_i,
   input  wire logic [7:0]   host_data_i,
   input  wire logic         host_cs_n_i,
   input  wire logic         host_rd_n_i,
   input  wire logic         host_wr_n_i,
   output logic      [7:0]   host_data_o,
   output logic              host_data_oe_n_o,
   output logic              host_irq_o,
   output logic              host_irq_oe_n_o,
   output logic              host_rx_rdy_n_o,
   output logic              host_tx_rdy_n_o,
   input  wire logic         chan_b_divided_clock_i,
   output logic              mpu_irq_o,
   output logic      [7:0]   mpu_vector_o
);
   ump_pkg::ump_host_regs_s hr, next_hr;
   ump_pkg::ump_ahb_req_s   aq, next_aq;
   logic [2:0]  hs1, hs2, hs3;
   logic [15:0] hb1, hb2;
   logic [2:0]  ck_s;
   logic [2:0]  shadow, next_shadow;
   logic [2:0]  err_acc, next_err_acc;
   logic        ovr, next_ovr, thre_pend, next_thre_pend;
   logic [ump_pkg::NSRC-1:0] stat, next_stat, mask, next_mask, ev;
   logic [15:0] ctrl, next_ctrl, pace, next_pace, tout, next_tout;
   logic [31:0] next_hrdata;
   logic [7:0]  next_hdata, line_status_reg, iir, next_vec;
   logic [3:0]  iir_id;
   logic        pace_ok, next_pace_ok, rx_to, next_rx_to;
   logic        h_hit, h_rd, h_wr, h_rd_act, ck_tick, ahb_go, dw;
   logic [2:0]  ha;
   logic [7:0]  hd;
   logic [10:0] rx_head;
   logic [7:0]  tx_head;
   logic [4:0]  rx_cnt, tx_cnt;
   logic        rx_full, rx_empty, tx_full, tx_empty;
   logic        rx_push, rx_pop, tx_push, tx_pop, rx_flush, tx_flush;
   logic        pa_exp, pb_exp, rto_exp, tto_exp;
   logic [2:0]  src;
   logic        any_src;

   // two-stage capture of host pins before use
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hs1  <= 3'h7;
         hs2  <= 3'h7;
         hs3  <= 3'h7;
         hb1  <= 16'h0000;
         hb2  <= 16'h0000;
         ck_s <= 3'h0;
      end else begin
         hs1  <= {host_cs_n_i, host_rd_n_i, host_wr_n_i};
         hs2  <= hs1;
         hs3  <= hs2;
         hb1  <= {host_addr_i, host_data_i};
         hb2  <= hb1;
         ck_s <= {ck_s[1:0], chan_b_divided_clock_i};
      end
   end

   // only address lines 7:3 are compared with the base
   assign h_hit    = hb2[15:11] == BASE[7:3];
   assign ha       = hb2[10:8];
   assign hd       = hb2[7:0];
   assign h_rd_act = h_hit && !hs2[2] && !hs2[1];
   // reads act on the leading edge, writes on the trailing edge
   assign h_rd     = h_rd_act && hs3[1];
   assign h_wr     = h_hit && !hs3[2] && hs2[0] && !hs3[0];
   assign ck_tick  = ck_s[1] && !ck_s[2];
   assign ahb_go   = hsel_i && htrans_i[1] && hready_i;
   assign dw       = aq.valid && aq.write;

   // eleven-bit entries: three error bits over the data
   ump_fifo #(.W(11), .D(16), .AW(4)) u_rx_fifo (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .flush_i (rx_flush),
      .push_i  (rx_push),
      .din_i   ({shadow, hwdata_i[7:0]}),
      .pop_i   (rx_pop),
      .head_o  (rx_head),
      .count_o (rx_cnt),
      .full_o  (rx_full),
      .empty_o (rx_empty)
   );

   ump_fifo #(.W(8), .D(16), .AW(4)) u_tx_fifo (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .flush_i (tx_flush),
      .push_i  (tx_push),
      .din_i   (hd),
      .pop_i   (tx_pop),
      .head_o  (tx_head),
      .count_o (tx_cnt),
      .full_o  (tx_full),
      .empty_o (tx_empty)
   );

   // low stage reloads itself, high stage restarts per character
   ump_timer #(.W(8)) u_pace_lo (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .reload_i   (rx_pop || pa_exp),
      .load_val_i (pace[7:0]),
      .tick_i     (ck_tick),
      .run_i      (1'b1),
      .expire_o   (pa_exp)
   );
   ump_timer #(.W(8)) u_pace_hi (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .reload_i   (rx_pop),
      .load_val_i (pace[15:8]),
      .tick_i     (pa_exp),
      .run_i      (1'b1),
      .expire_o   (pb_exp)
   );
   // timeouts restart on every access of their fifo
   ump_timer #(.W(8)) u_rx_tout (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .reload_i   (rx_push || rx_pop),
      .load_val_i (tout[7:0]),
      .tick_i     (ck_tick),
      .run_i      (!rx_empty),
      .expire_o   (rto_exp)
   );
   ump_timer #(.W(8)) u_tx_tout (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .reload_i   (tx_push || tx_pop),
      .load_val_i (tout[15:8]),
      .tick_i     (ck_tick),
      .run_i      (!tx_empty),
      .expire_o   (tto_exp)
   );

   always_comb begin
      // head errors only count while an entry is present
      line_status_reg = {|(rx_empty ? 3'h0 : rx_head[10:8]), tx_empty, tx_empty,
             err_acc[2:0] | (rx_empty ? 3'h0 : rx_head[10:8]), ovr, !rx_empty};
      // host interrupt identification by the usual priority
      if (hr.ier[2] && |line_status_reg[4:1]) begin
         iir_id = ump_pkg::IIR_LS;
      end else if (hr.ier[0] && rx_cnt >= ump_pkg::ump_trig(hr.fifo_control_reg[7:6])) begin
         // trigger level from fifo control bits 7:6
         iir_id = ump_pkg::IIR_RDA;
      end else if (hr.ier[0] && rx_to) begin
         iir_id = ump_pkg::IIR_TO;
      end else if (hr.ier[1] && thre_pend) begin
         iir_id = ump_pkg::IIR_THRE;
      end else if (hr.ier[3] && |hr.msr[3:0]) begin
         iir_id = ump_pkg::IIR_MS;
      end else begin
         iir_id = ump_pkg::IIR_NONE;
      end
      iir = {{2{hr.fifo_control_reg[0]}}, 2'b00, iir_id};
   end

   // host side group
   always_comb begin
      next_hr        = hr;
      next_shadow    = shadow;
      next_err_acc   = err_acc;
      next_ovr       = ovr;
      next_thre_pend = thre_pend;
      next_hdata     = host_data_o;
      rx_pop         = 1'b0;
      tx_push        = 1'b0;
      rx_push        = 1'b0;
      rx_flush       = 1'b0;
      tx_flush       = 1'b0;
      ev             = '0;
      if (h_rd) begin
         unique case (ha)
            ump_pkg::HOFF_DATA: begin
               if (hr.line_control_reg[7]) begin
                  next_hdata = hr.dll;
               end else begin
                  next_hdata = rx_head[7:0];
                  rx_pop     = 1'b1;
                  ev[ump_pkg::SRC_RXRD] = 1'b1;
                  // gather errors of every character read
                  next_err_acc = err_acc | (rx_empty ? 3'h0 : rx_head[10:8]);
               end
            end
            ump_pkg::HOFF_IER: next_hdata = hr.line_control_reg[7] ?
               hr.divisor_latch_high : hr.ier;
            ump_pkg::HOFF_IIR: begin
               next_hdata = iir;
               if (iir_id == ump_pkg::IIR_THRE) begin
                  next_thre_pend = 1'b0;
               end
            end
            ump_pkg::HOFF_LINE: next_hdata = hr.line_control_reg;
            ump_pkg::HOFF_MODM: next_hdata = hr.modem_control_reg;
            ump_pkg::HOFF_LSTS: begin
               next_hdata   = line_status_reg;
               // only this read clears the error flags
               next_err_acc = 3'h0;
               next_ovr     = 1'b0;
            end
            ump_pkg::HOFF_MSR: next_hdata = hr.msr;
            ump_pkg::HOFF_SCR: next_hdata = hr.scr;
         endcase
      end
      if (h_wr) begin
         unique case (ha)
            ump_pkg::HOFF_DATA: begin
               if (hr.line_control_reg[7]) begin
                  next_hr.dll = hd;
                  ev[ump_pkg::SRC_DIV] = 1'b1;
               end else begin
                  tx_push        = 1'b1;
                  next_thre_pend = 1'b0;
                  ev[ump_pkg::SRC_TXWR] = 1'b1;
               end
            end
            ump_pkg::HOFF_IER: begin
               if (hr.line_control_reg[7]) begin
                  next_hr.divisor_latch_high = hd;
                  ev[ump_pkg::SRC_DIV] = 1'b1;
               end else begin
                  next_hr.ier = {4'h0, hd[3:0]};
               end
            end
            ump_pkg::HOFF_IIR: begin
               next_hr.fifo_control_reg = {hd[7:6], 5'h00, hd[0]};
               rx_flush    = hd[1];
               tx_flush    = hd[2];
               ev[ump_pkg::SRC_FIFO] = 1'b1;
            end
            ump_pkg::HOFF_LINE: begin
               next_hr.line_control_reg = hd;
               ev[ump_pkg::SRC_LINE] = 1'b1;
            end
            ump_pkg::HOFF_MODM: begin
               next_hr.modem_control_reg = {3'h0, hd[4:0]};
               ev[ump_pkg::SRC_MDM] = 1'b1;
            end
            ump_pkg::HOFF_SCR: next_hr.scr = hd;
            default: ;
         endcase
      end
      if (dw && aq.addr == ump_pkg::ADDR_SHADOW) begin
         // shadow bits are written ahead of their character
         next_shadow = hwdata_i[2:0];
      end
      if (dw && aq.addr == ump_pkg::ADDR_RX_DATA) begin
         rx_push  = 1'b1;
         // shadow copied into the entry, then cleared
         next_shadow = 3'h0;
         next_ovr    = next_ovr || rx_full;
      end
      if (dw && aq.addr == ump_pkg::ADDR_HOST_MISC) begin
         next_hr.msr = hwdata_i[7:0];
      end
      // a transmit fifo that just drained re-arms the empty interrupt
      if (tx_pop && tx_cnt == 5'h01) begin
         next_thre_pend = 1'b1;
      end
      ev[ump_pkg::SRC_TXTO] = tto_exp;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hr          <= '0;
         shadow      <= 3'h0;
         err_acc     <= 3'h0;
         ovr         <= 1'b0;
         thre_pend   <= 1'b1;
         host_data_o <= 8'h00;
      end else begin
         hr          <= next_hr;
         shadow      <= next_shadow;
         err_acc     <= next_err_acc;
         ovr         <= next_ovr;
         thre_pend   <= next_thre_pend;
         host_data_o <= next_hdata;
      end
   end

   // lowest index pending and unmasked wins
   always_comb begin
      src     = 3'h0;
      any_src = 1'b0;
      for (int i = ump_pkg::NSRC - 1; i >= 0; i--) begin
         if (stat[i] && mask[i]) begin
            src     = 3'(i);
            any_src = 1'b1;
         end
      end
   end

   // mpu side group
   always_comb begin
      next_aq     = '0;
      next_stat   = stat;
      next_mask   = mask;
      next_ctrl   = ctrl;
      next_pace   = pace;
      next_tout   = tout;
      next_hrdata = hrdata_o;
      tx_pop      = 1'b0;
      next_pace_ok = pace_ok;
      next_rx_to  = rx_to;
      if (ahb_go) begin
         next_aq = '{addr: haddr_i[7:0], write: hwrite_i, valid: 1'b1};
         unique case (haddr_i[7:0])
            ump_pkg::ADDR_RX_DATA:   next_hrdata = {27'h0, rx_cnt};
            ump_pkg::ADDR_TX_DATA: begin
               next_hrdata = {23'h0, !tx_empty, tx_head};
               tx_pop      = !hwrite_i;
            end
            ump_pkg::ADDR_IRQ_STAT:  next_hrdata = {25'h0, stat};
            ump_pkg::ADDR_IRQ_MASK:  next_hrdata = {25'h0, mask};
            ump_pkg::ADDR_CTRL:      next_hrdata = {16'h0, ctrl};
            ump_pkg::ADDR_PACE:      next_hrdata = {16'h0, pace};
            ump_pkg::ADDR_TOUT:      next_hrdata = {16'h0, tout};
            ump_pkg::ADDR_HOST_CFG:  next_hrdata = {hr.modem_control_reg, hr.line_control_reg,
               hr.divisor_latch_high, hr.dll};
            ump_pkg::ADDR_HOST_MISC: next_hrdata = {hr.scr, hr.ier, hr.fifo_control_reg,
               3'h0, tx_cnt};
            default:                 next_hrdata = 32'h0000_0000;
         endcase
      end
      if (dw) begin
         unique case (aq.addr)
            ump_pkg::ADDR_IRQ_STAT: next_stat = stat & ~hwdata_i[ump_pkg::NSRC-1:0];
            ump_pkg::ADDR_IRQ_MASK: next_mask = hwdata_i[ump_pkg::NSRC-1:0];
            ump_pkg::ADDR_CTRL:     next_ctrl = hwdata_i[15:0];
            ump_pkg::ADDR_PACE:     next_pace = hwdata_i[15:0];
            ump_pkg::ADDR_TOUT:     next_tout = hwdata_i[15:0];
            default: ;
         endcase
      end
      // new events win over a same-cycle clear
      next_stat = next_stat | ev;
      // a character may go once the high stage has counted down its low-stage periods
      if (rx_pop) begin
         next_pace_ok = 1'b0;
      end else if (pb_exp || !ctrl[ump_pkg::CTRL_PACE]) begin
         next_pace_ok = 1'b1;
      end
      // timeout ends on access or on reaching the trigger
      if (rx_push || rx_pop || rx_cnt >= ump_pkg::ump_trig(hr.fifo_control_reg[7:6])) begin
         next_rx_to = 1'b0;
      end else if (rto_exp) begin
         next_rx_to = 1'b1;
      end
      // per-source mask plus one global enable
      next_vec = ump_pkg::RST_OPCODE;
      // mode 2 places the source number in the vector
      if (ctrl[ump_pkg::CTRL_MODE2]) begin
         next_vec = {ctrl[ump_pkg::CTRL_VEC+4 +: 4], src, 1'b0};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aq              <= '0;
         stat            <= '0;
         mask            <= '0;
         ctrl            <= ump_pkg::CTRL_RST;
         pace            <= 16'h0000;
         tout            <= 16'h0000;
         hrdata_o        <= 32'h0000_0000;
         hreadyout_o     <= 1'b1;
         hresp_o         <= 1'b0;
         pace_ok         <= 1'b1;
         rx_to           <= 1'b0;
         mpu_irq_o       <= 1'b0;
         mpu_vector_o    <= ump_pkg::RST_OPCODE;
         host_irq_o      <= 1'b0;
         host_irq_oe_n_o <= 1'b0;
         host_data_oe_n_o <= 1'b1;
         host_rx_rdy_n_o <= 1'b1;
         host_tx_rdy_n_o <= 1'b1;
      end else begin
         aq              <= next_aq;
         stat            <= next_stat;
         mask            <= next_mask;
         ctrl            <= next_ctrl;
         pace            <= next_pace;
         tout            <= next_tout;
         hrdata_o        <= next_hrdata;
         hreadyout_o     <= 1'b1;
         hresp_o         <= 1'b0;
         pace_ok         <= next_pace_ok;
         rx_to           <= next_rx_to;
         mpu_irq_o       <= ctrl[ump_pkg::CTRL_GIE] && any_src;
         mpu_vector_o    <= next_vec;
         // shared mode only pulls low, otherwise drives the level
         host_irq_o      <= !ctrl[ump_pkg::CTRL_WAND] &&
                            hr.modem_control_reg[3] && iir_id != ump_pkg::IIR_NONE;
         host_irq_oe_n_o <= ctrl[ump_pkg::CTRL_WAND] &&
                            !(hr.modem_control_reg[3] && iir_id != ump_pkg::IIR_NONE);
         host_data_oe_n_o <= !h_rd_act;
         // handshake lines follow fifo state, the receive line also pacing
         host_rx_rdy_n_o <= !(ctrl[ump_pkg::CTRL_DMA] && !rx_empty && pace_ok);
         host_tx_rdy_n_o <= !(ctrl[ump_pkg::CTRL_DMA] && !tx_full);
      end
   end
endmodule : ump_port

// ===== design/ump_timer.sv
// reloadable down counter with expiry pulse
module ump_timer #(
   parameter int W = 8
) (
   input  wire logic          mclk_i,
   input  wire logic          rst_n_i,
   input  wire logic          reload_i,
   input  wire logic [W-1:0]  load_val_i,
   input  wire logic          tick_i,
   input  wire logic          run_i,
   output logic               expire_o
);
   logic [W-1:0] count, next_count;
   logic         next_expire;

   always_comb begin
      next_count  = count;
      next_expire = 1'b0;
      if (reload_i) begin
         next_count = load_val_i;
      end else if (tick_i && run_i && count != '0) begin
         next_count  = count - 1'b1;
         next_expire = count == W'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count    <= '0;
         expire_o <= 1'b0;
      end else begin
         count    <= next_count;
         expire_o <= next_expire;
      end
   end
endmodule : ump_timer

// ===== verif/tb_ump_port.sv
// self-checking bench of the host port block
module tb_ump_port;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] B = ump_pkg::HOST_BASE;
   localparam logic [7:0] OFF [4] = '{8'h00, 8'h04, 8'h03, 8'h02};
   localparam int         SRC [4] = '{0, 1, 2, 4};
   logic        mclk_i = 1'b0, rst_n_i = 1'b0, tick = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        rdy, cs_n, rd_n, wr_n, txr_n, mirq, hirq;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [7:0]  ha, hd, hq, vec, b;
   int          fail_count = 0;
   int          comparisons = 0;
   always #12.5 mclk_i = ~mclk_i;
   always #400 tick = ~tick;
   ump_port i_ump_port (.mclk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata),
      .hreadyout_o(rdy), .hresp_o(), .host_addr_i(ha), .host_data_i(hd), .host_cs_n_i(cs_n),
      .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_data_o(hq), .host_data_oe_n_o(),
      .host_irq_o(hirq), .host_irq_oe_n_o(), .host_rx_rdy_n_o(), .host_tx_rdy_n_o(txr_n),
      .chan_b_divided_clock_i(tick), .mpu_irq_o(mirq), .mpu_vector_o(vec));
   ump_host i_ump_host (.mclk_i, .rdata_i(hq), .addr_o(ha), .data_o(hd), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n));
   task automatic test_done();
      $display("mismatches %0d of %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         fail_count++;
         test_done();
      end
   endtask : wt
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, w};
      wt();
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      wt();
      q = hrdata;
   endtask : ahb
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      ahb(8'h10, 1'b1, 32'h3F);
      ahb(8'h14, 1'b1, 32'h1);
      for (int i = 0; i < 4; i++) begin
         i_ump_host.acc(B | OFF[i], 8'h1, 8'h03, b);
         ahb(8'h0C, 1'b0, 32'h0);
         chk(q & 32'h3F, 32'h1 << SRC[i]);
         chk({31'h0, mirq}, 32'h1);
         ahb(8'h0C, 1'b1, 32'h7F);
      end
      ahb(8'h14, 1'b1, 32'h0);
      i_ump_host.acc(8'h1A, 8'h1, 8'h03, b);
      i_ump_host.acc(B | 8'h04, 8'h1, 8'h0B, b);
      i_ump_host.acc(B | 8'h03, 8'h1, 8'h03, b);
      ahb(8'h0C, 1'b0, 32'h0);
      chk(q & 32'h3F, 32'h6);
      chk({31'h0, mirq}, 32'h0);
      ahb(8'h14, 1'b1, 32'hA003);
      ahb(8'h0C, 1'b0, 32'h0);
      chk({24'h0, vec}, 32'hA2);
      ahb(8'h14, 1'b1, 32'h1);
      ahb(8'h0C, 1'b0, 32'h0);
      chk({24'h0, vec}, 32'hFF);
      ahb(8'h04, 1'b1, 32'h1);
      ahb(8'h00, 1'b1, 32'h55);
      ahb(8'h00, 1'b1, 32'h66);
      i_ump_host.acc(B | 8'h01, 8'h1, 8'h01, b);
      chk({31'h0, hirq}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         i_ump_host.acc(B, 8'h0, 8'h00, b);
         chk({24'h0, b}, 32'h55 + 32'(i) * 32'h11);
      end
      i_ump_host.acc(B | 8'h05, 8'h0, 8'h00, b);
      chk({24'h0, b & 8'h1C}, 32'h4);
      i_ump_host.acc(B | 8'h05, 8'h0, 8'h00, b);
      chk({24'h0, b & 8'h1C}, 32'h0);
      ahb(8'h14, 1'b1, 32'h10);
      ahb(8'h08, 1'b0, 32'h0);
      chk(q, 32'h103);
      for (int i = 0; i < 16; i++)
         i_ump_host.acc(B, 8'h1, 8'(i), b);
      chk({31'h0, txr_n}, 32'h1);
      ahb(8'h08, 1'b0, 32'h0);
      chk(q, 32'h100);
      ahb(8'h24, 1'b0, 32'h0);
      chk(q & 32'h1F, 32'hF);
      chk({31'h0, txr_n}, 32'h0);
      test_done();
   end
endmodule : tb_ump_port

// ===== verif/ump_host.sv
// pc-side host bus model
module ump_host (
   input  wire logic       mclk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] data_o,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr_o = 8'h00;
      data_o = 8'h00;
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
   end
   task automatic acc(input logic [7:0] a, w, d, output logic [7:0] q);
      addr_o <= a;
      data_o <= d;
      repeat (4) @(posedge mclk_i);
      {cs_n_o, rd_n_o, wr_n_o} <= {1'b0, w[0], !w[0]};
      repeat (6) @(posedge mclk_i);
      q = rdata_i;
      {cs_n_o, rd_n_o, wr_n_o} <= 3'h7;
      repeat (3) @(posedge mclk_i);
      // floating bus, never the last value
      data_o <= ~d;
      repeat (3) @(posedge mclk_i);
   endtask : acc
endmodule : ump_host

// ===== verif/ump_props.sv
// pin-level assertions of the host port block
module ump_props (
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       hreadyout_o,
   input wire logic       hresp_o,
   input wire logic       host_cs_n_i,
   input wire logic       host_rd_n_i,
   input wire logic [7:0] host_data_o,
   input wire logic       host_data_oe_n_o,
   input wire logic       host_irq_o,
   input wire logic       host_irq_oe_n_o,
   input wire logic       mpu_irq_o,
   input wire logic [7:0] mpu_vector_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bad answer");
   read_lat_a: assert property ($fell(host_rd_n_i) && !host_cs_n_i |->
      ##[3:5] !host_data_oe_n_o) else $error("read late");
   oe_cause_a: assert property ($fell(host_data_oe_n_o) |->
      !$past(host_rd_n_i, 2)) else $error("drive unasked");
   oe_end_a: assert property ($rose(host_data_oe_n_o) |->
      $past(host_rd_n_i || host_cs_n_i)) else $error("early release");
   oe_idle_a: assert property ((host_rd_n_i || host_cs_n_i) [*6] |->
      host_data_oe_n_o) else $error("drive stuck");
   dout_hold_a: assert property (!host_data_oe_n_o && $past(!host_data_oe_n_o) |->
      $stable(host_data_o)) else $error("data moved");
   irq_pin_a: assert property (host_irq_o |-> !host_irq_oe_n_o) else $error("irq clash");
   vec_form_a: assert property (mpu_vector_o == 8'hFF || !mpu_vector_o[0])
      else $error("bad vector");
   read_c: cover property ($fell(host_data_oe_n_o));
   mpu_irq_c: cover property ($rose(mpu_irq_o));
   mode2_c: cover property (mpu_vector_o != 8'hFF);
endmodule : ump_props
bind ump_port ump_props i_ump_props (.*);
